/* verilog/mbsi_pkg.sv */
/*
  Package for the host-bus slave and interrupt controller of the line multiplexer.
  Holds bit positions, timing constants, reset values and the bus carrier structs.
  Assumes a 100 MHz system clock.
*/
package mbsi_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;                     // System clock period
  localparam int CLR_PULSE_NS    = 2400;                   // Master clear one-shot
  localparam int CLR_EXTRA_NS    = 300;                    // Read-back stretch
  localparam int CLR_PULSE_CYC   = CLR_PULSE_NS / CLK_PERIOD_NS;
  localparam int CLR_EXTRA_CYC   = (CLR_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 9;                      // Counter width
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;
  localparam logic [CNT_W-1:0] CLR_LOAD = CNT_W'(CLR_PULSE_CYC);
  localparam logic [CNT_W-1:0] EXT_LOAD = CNT_W'(CLR_EXTRA_CYC);

  // ****************************************************************
  // Control and status register bit positions
  // ****************************************************************
  localparam int CSR_CLR_BIT   = 4;                        // Master clear
  localparam int CSR_RIE_BIT   = 6;                        // Receiver interrupt enable
  localparam int CSR_SAE_BIT   = 12;                       // Silo alarm enable
  localparam int CSR_TIE_BIT   = 14;                       // Transmit interrupt enable
  localparam int ADDR_BYTE_BIT = 0;                        // Byte address bit
  localparam int VEC_LO_BIT    = 3;                        // Lowest switch vector bit
  localparam int VEC_HI_BIT    = 8;                        // Highest switch vector bit
  localparam int VEC_TX_BIT    = 2;                        // Transmitter vector bit
  localparam int SILO_ALARM_LEVEL = 16;                    // Characters for alarm
  localparam int RX_DONE_LEVEL    = 1;                     // Characters for done

  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [3:0]  DTR_ZERO  = 4'h0;
  localparam logic [1:0]  LANE_NONE = 2'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic sync_n;                                          // Bus sync, active low
    logic dout_n;                                          // Write strobe, active low
    logic din_n;                                           // Read strobe, active low
    logic wtbt_n;                                          // Write/byte, active low
    logic iaki_n;                                          // Acknowledge in, active low
    logic init_n;                                          // Bus initialize, active low
  } mbsi_bus_s;

  typedef struct packed {
    logic       rx_char_ready;                             // Receive buffer has a char
    logic       silo_alarm;                                // Silo reached alarm level
    logic       tx_ready;                                  // Transmit register empty
  } mbsi_core_s;

endpackage : mbsi_pkg

/* verilog/mbsi_top.sv */
/*
  Host-bus slave end and two-channel vectored interrupt logic.
  Assumes address decode, register contents and UART core sit outside;
  bus inputs are synchronous to clk; open-drain bus outputs are given as
  drive enables (high = pull line low).
*/
`timescale 1ns/1ps
module mbsi_top (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire mbsi_pkg::mbsi_bus_s bus_in,
  input  wire logic               address_hit,
  input  wire logic               addr_bit0,
  input  wire logic               csr_select,
  input  wire logic [15:0]        bus_data_in,
  input  wire logic               read_drive,
  input  wire logic [15:0]        read_data,
  input  wire mbsi_pkg::mbsi_core_s core_in,
  input  wire logic [5:0]         vector_switches,
  input  wire logic               dtr_write,
  input  wire logic [3:0]         dtr_data,
  output logic                    reply_oe_r,
  output logic                    irq_oe_r,
  output logic                    iako_n_r,
  output logic [15:0]             bus_data_out_r,
  output logic                    bus_data_oe_r,
  output logic                    low_byte_write_r,
  output logic                    high_byte_write_r,
  output logic                    reg_select_r,
  output logic                    master_clear_pulse_r,
  output logic                    modem_line_clear_r,
  output logic [3:0]              terminal_ready_bits_r,
  output logic                    vector_drive_r,
  output logic                    vector_bit_two_sel_r,
  output logic                    rx_interrupt_enable_r,
  output logic                    alarm_interrupt_enable_r,
  output logic                    tx_interrupt_enable_r,
  output logic                    clear_readback_r
);
  import mbsi_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Byte lanes {high, low} for a write
  function automatic logic [1:0] lane_sel(input logic wtbt_n, input logic a0);
    if (wtbt_n) begin
      lane_sel = 2'h3;                                     // Word: both
    end else if (a0) begin
      lane_sel = 2'h2;                                     // High byte
    end else begin
      lane_sel = 2'h1;                                     // Low byte
    end
  endfunction : lane_sel

  typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT_END} mbsi_cyc_e;

  mbsi_cyc_e        cyc_r;                                 // Bus cycle state
  logic             sync_d_r;                              // Previous sync level
  logic             a0_r;                                  // Latched address bit 0
  logic             hit_r;                                 // Latched decode
  logic [CNT_W-1:0] clr_cnt_r;                             // One-shot counter
  logic [CNT_W-1:0] ext_cnt_r;                             // Read-back stretch counter
  logic             rx_pend_r;                             // Receiver request pending
  logic             tx_pend_r;                             // Transmitter request pending
  logic             vec_tx_r;                              // Vector cycle is transmitter
  logic             chan_clear;                            // Any clear event
  logic             csr_low_wr;                            // CONTROL_STATUS_REG low byte write strobe
  logic             csr_high_wr;                           // CONTROL_STATUS_REG high byte write strobe
  logic             rx_cond;                               // Enabled receiver condition
  logic             tx_cond;                               // Enabled transmitter condition
  logic             ack_here;                              // Acknowledge with read strobe
  logic [1:0]       lanes;                                 // Lanes for this write

  // ****************************************************************
  // Combinational terms
  // ****************************************************************
  assign lanes       = lane_sel(bus_in.wtbt_n, a0_r);
  assign csr_low_wr  = (cyc_r == ST_ADDR) && !bus_in.dout_n && hit_r && csr_select && lanes[0];
  assign csr_high_wr = (cyc_r == ST_ADDR) && !bus_in.dout_n && hit_r && csr_select && lanes[1];
  assign chan_clear  = master_clear_pulse_r || !bus_in.init_n;
  // Alarm enable hides receiver done
  assign rx_cond = (rx_interrupt_enable_r && !alarm_interrupt_enable_r && core_in.rx_char_ready)
                 || (alarm_interrupt_enable_r && core_in.silo_alarm);
  assign tx_cond = tx_interrupt_enable_r && core_in.tx_ready;
  assign ack_here = !bus_in.din_n && !bus_in.iaki_n;

  // ****************************************************************
  // Write cycle sequencing
  // ****************************************************************
  // Latch decode on sync leading edge, write on data strobe, end on sync
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_r    <= ST_IDLE;
      sync_d_r <= 1'b0;
      a0_r     <= 1'b0;
      hit_r    <= 1'b0;
    end else begin
      sync_d_r <= !bus_in.sync_n;
      case (cyc_r)
        ST_IDLE: begin
          if (!bus_in.sync_n && !sync_d_r) begin
            a0_r  <= addr_bit0;
            hit_r <= address_hit;
            cyc_r <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (bus_in.sync_n) begin
            cyc_r <= ST_IDLE;
          end else if (!bus_in.dout_n && hit_r) begin
            cyc_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bus_in.dout_n) begin
            cyc_r <= ST_WAIT_END;
          end
        end
        default: begin
          if (bus_in.sync_n) begin
            cyc_r <= ST_IDLE;
            hit_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Byte lane strobes and register select, released with sync
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_byte_write_r  <= 1'b0;
      high_byte_write_r <= 1'b0;
      reg_select_r      <= 1'b0;
    end else if (bus_in.sync_n) begin
      low_byte_write_r  <= 1'b0;
      high_byte_write_r <= 1'b0;
      reg_select_r      <= 1'b0;
    end else begin
      reg_select_r <= hit_r || ((cyc_r == ST_IDLE) && address_hit);
      if ((cyc_r == ST_ADDR) && !bus_in.dout_n && hit_r) begin
        low_byte_write_r  <= lanes[0];
        high_byte_write_r <= lanes[1];
      end else if (bus_in.dout_n) begin
        low_byte_write_r  <= 1'b0;
        high_byte_write_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Reply and data drivers
  // ****************************************************************
  // Reply for write, read or vector; vector overrides decode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reply_oe_r     <= 1'b0;
      bus_data_oe_r  <= 1'b0;
      bus_data_out_r <= DATA_ZERO;
    end else if (vector_drive_r) begin
      reply_oe_r     <= 1'b1;
      bus_data_oe_r  <= 1'b1;
      bus_data_out_r <= DATA_ZERO;
      bus_data_out_r[VEC_HI_BIT:VEC_LO_BIT] <= vector_switches;
      bus_data_out_r[VEC_TX_BIT] <= vec_tx_r;
    end else if (hit_r && !bus_in.sync_n && !bus_in.din_n && read_drive) begin
      reply_oe_r     <= 1'b1;
      bus_data_oe_r  <= 1'b1;
      bus_data_out_r <= read_data;
    end else begin
      reply_oe_r     <= (cyc_r == ST_DATA) && !bus_in.dout_n;
      bus_data_oe_r  <= 1'b0;
      bus_data_out_r <= DATA_ZERO;
    end
  end

  // ****************************************************************
  // Enables held in the interrupt logic
  // ****************************************************************
  // Written through CONTROL_STATUS_REG byte strobes, cleared by any clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_interrupt_enable_r    <= 1'b0;
      alarm_interrupt_enable_r <= 1'b0;
      tx_interrupt_enable_r    <= 1'b0;
    end else if (chan_clear) begin
      rx_interrupt_enable_r    <= 1'b0;
      alarm_interrupt_enable_r <= 1'b0;
      tx_interrupt_enable_r    <= 1'b0;
    end else begin
      if (csr_low_wr) begin
        rx_interrupt_enable_r <= bus_data_in[CSR_RIE_BIT];
      end
      if (csr_high_wr) begin
        alarm_interrupt_enable_r <= bus_data_in[CSR_SAE_BIT];
        tx_interrupt_enable_r    <= bus_data_in[CSR_TIE_BIT];
      end
    end
  end

  // ****************************************************************
  // Master clear one-shot and read-back stretch
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clr_cnt_r            <= CNT_ZERO;
      master_clear_pulse_r <= 1'b0;
    end else if (csr_low_wr && bus_data_in[CSR_CLR_BIT] && clr_cnt_r == CNT_ZERO) begin
      clr_cnt_r            <= CLR_LOAD;
      master_clear_pulse_r <= 1'b1;
    end else if (clr_cnt_r != CNT_ZERO) begin
      clr_cnt_r            <= clr_cnt_r - CNT_ONE;
      master_clear_pulse_r <= (clr_cnt_r != CNT_ONE);
    end else begin
      master_clear_pulse_r <= 1'b0;
    end
  end

  // Modem clear follows bus initialize
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modem_line_clear_r <= 1'b0;
    end else begin
      modem_line_clear_r <= !bus_in.init_n;
    end
  end

  // Read-back: OR of both clears, stretched after they end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_cnt_r        <= CNT_ZERO;
      clear_readback_r <= 1'b0;
    end else if (master_clear_pulse_r || modem_line_clear_r) begin
      ext_cnt_r        <= EXT_LOAD;
      clear_readback_r <= 1'b1;
    end else if (ext_cnt_r != CNT_ZERO) begin
      ext_cnt_r        <= ext_cnt_r - CNT_ONE;
      clear_readback_r <= 1'b1;
    end else begin
      clear_readback_r <= 1'b0;
    end
  end

  // Terminal ready bits: modem clear only, master clear leaves them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      terminal_ready_bits_r <= DTR_ZERO;
    end else if (modem_line_clear_r) begin
      terminal_ready_bits_r <= DTR_ZERO;
    end else if (dtr_write) begin
      terminal_ready_bits_r <= dtr_data;
    end
  end

  // ****************************************************************
  // Interrupt channels
  // ****************************************************************
  // Pending requests; set beats acknowledge clear only when not taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_pend_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end else if (chan_clear) begin
      rx_pend_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end else if (ack_here && !vector_drive_r && (rx_pend_r || tx_pend_r)) begin
      rx_pend_r <= rx_pend_r ? 1'b0 : rx_cond;
      tx_pend_r <= rx_pend_r ? (tx_pend_r && tx_interrupt_enable_r) : 1'b0;
    end else begin
      rx_pend_r <= (rx_pend_r && (rx_interrupt_enable_r || alarm_interrupt_enable_r))
                 || rx_cond;
      tx_pend_r <= (tx_pend_r && tx_interrupt_enable_r) || tx_cond;
    end
  end

  // Vector drive across acknowledge; receiver first in the chain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_drive_r       <= 1'b0;
      vector_bit_two_sel_r <= 1'b0;
      vec_tx_r             <= 1'b0;
      irq_oe_r             <= 1'b0;
      iako_n_r             <= 1'b1;
    end else begin
      if (!vector_drive_r && ack_here && (rx_pend_r || tx_pend_r) && !chan_clear) begin
        vector_drive_r       <= 1'b1;
        vector_bit_two_sel_r <= !rx_pend_r;
        vec_tx_r             <= !rx_pend_r;
      end else if (vector_drive_r && bus_in.din_n) begin
        vector_drive_r       <= 1'b0;
        vector_bit_two_sel_r <= 1'b0;
        vec_tx_r             <= 1'b0;
      end
      irq_oe_r <= (rx_pend_r || tx_pend_r) && !vector_drive_r && !ack_here;
      iako_n_r <= bus_in.iaki_n || rx_pend_r || tx_pend_r || vector_drive_r;
    end
  end

endmodule : mbsi_top

/* sim/mbsi_top_sva.sv */
/*
  Concurrent checks on the bus slave and interrupt logic ports.
  Assumes it is bound to mbsi_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module mbsi_top_sva (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire mbsi_pkg::mbsi_bus_s  bus_in,
  input wire mbsi_pkg::mbsi_core_s core_in,
  input wire logic [5:0]           vector_switches,
  input wire logic                 reply_oe_r,
  input wire logic                 irq_oe_r,
  input wire logic [15:0]          bus_data_out_r,
  input wire logic                 bus_data_oe_r,
  input wire logic                 low_byte_write_r,
  input wire logic                 high_byte_write_r,
  input wire logic                 reg_select_r,
  input wire logic                 master_clear_pulse_r,
  input wire logic                 modem_line_clear_r,
  input wire logic [3:0]           terminal_ready_bits_r,
  input wire logic                 vector_drive_r,
  input wire logic                 vector_bit_two_sel_r,
  input wire logic                 rx_interrupt_enable_r,
  input wire logic                 alarm_interrupt_enable_r,
  input wire logic                 tx_interrupt_enable_r,
  input wire logic                 clear_readback_r
);
  import mbsi_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************************************
  // Pulse length counters
  // ****************************************************************
  logic [CNT_W-1:0] pcnt_r;                                // Clear pulse cycles
  logic [CNT_W-1:0] rcnt_r;                                // Read-back cycles
  // Count consecutive high cycles of the master clear pulse and of the read-back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcnt_r <= CNT_ZERO;
      rcnt_r <= CNT_ZERO;
    end else begin
      pcnt_r <= master_clear_pulse_r ? pcnt_r + CNT_ONE : CNT_ZERO;
      rcnt_r <= clear_readback_r ? rcnt_r + CNT_ONE : CNT_ZERO;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_reply_drop: assert property (p_reply_drop) else $error("reply held after write strobe");
  property p_reply_drop; $rose(bus_in.dout_n) && !vector_drive_r |=> !reply_oe_r; endproperty
  a_release: assert property (p_release) else $error("selects held after sync");
  property p_release;
    $rose(bus_in.sync_n) |=> !low_byte_write_r && !high_byte_write_r && !reg_select_r;
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("both lanes on a byte write");
  property p_word_lanes; low_byte_write_r && high_byte_write_r |-> bus_in.wtbt_n; endproperty
  a_vec_reply: assert property (p_vec_reply) else $error("no reply to vector");
  property p_vec_reply; vector_drive_r |=> reply_oe_r; endproperty
  a_vec_data: assert property (p_vec_data) else $error("wrong vector on data lines");
  property p_vec_data;
    vector_drive_r && reply_oe_r |-> bus_data_oe_r && bus_data_out_r[VEC_HI_BIT:VEC_LO_BIT]
      == vector_switches && bus_data_out_r[VEC_TX_BIT] == vector_bit_two_sel_r;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not taken");
  property p_ack;
    $fell(bus_in.iaki_n) && !bus_in.din_n && irq_oe_r |=> vector_drive_r && !irq_oe_r;
  endproperty
  a_vec_drop: assert property (p_vec_drop) else $error("vector held after read strobe");
  property p_vec_drop;
    $rose(bus_in.din_n) && vector_drive_r |=> !vector_drive_r && !vector_bit_two_sel_r
      ##1 !reply_oe_r && !bus_data_oe_r;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("no request for ready transmitter");
  property p_tx_irq; $rose(tx_interrupt_enable_r) && core_in.tx_ready |-> ##[0:3] irq_oe_r; endproperty
  a_clr_len: assert property (p_clr_len) else $error("clear pulse length wrong");
  property p_clr_len; $fell(master_clear_pulse_r) |-> pcnt_r == CLR_LOAD; endproperty
  a_rb_len: assert property (p_rb_len) else $error("read-back length wrong");
  property p_rb_len;
    $fell(clear_readback_r) && rcnt_r > 9'h064 |-> rcnt_r == CLR_LOAD + EXT_LOAD;
  endproperty
  a_clr_chan: assert property (p_clr_chan) else $error("channels kept through clear");
  property p_clr_chan;
    $rose(master_clear_pulse_r) |-> ##[0:2] !irq_oe_r && !rx_interrupt_enable_r
      && !alarm_interrupt_enable_r && !tx_interrupt_enable_r;
  endproperty
  a_init: assert property (p_init) else $error("no modem clear on initialize");
  property p_init; $fell(bus_in.init_n) |=> modem_line_clear_r; endproperty
  a_mdm: assert property (p_mdm) else $error("ready bits kept in modem clear");
  property p_mdm; modem_line_clear_r |=> terminal_ready_bits_r == DTR_ZERO; endproperty
endmodule : mbsi_top_sva
bind mbsi_top mbsi_top_sva mbsi_top_sva_inst (.clk, .rstn, .bus_in, .core_in,
  .vector_switches, .reply_oe_r, .irq_oe_r, .bus_data_out_r, .bus_data_oe_r,
  .low_byte_write_r, .high_byte_write_r, .reg_select_r, .master_clear_pulse_r,
  .modem_line_clear_r, .terminal_ready_bits_r, .vector_drive_r, .vector_bit_two_sel_r,
  .rx_interrupt_enable_r, .alarm_interrupt_enable_r, .tx_interrupt_enable_r,
  .clear_readback_r);

/* sim/mbsi_host.sv */
/*
  Host processor model on the handshake bus: writes, vector reads, initialize.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module mbsi_host (
  input  wire logic          clk,
  input  wire logic          reply_oe_r,
  input  wire logic          irq_oe_r,
  input  wire logic [15:0]   bus_data_out_r,
  input  wire logic [1:0]    lanes,
  output mbsi_pkg::mbsi_bus_s bus_in,
  output logic               address_hit,
  output logic               addr_bit0,
  output logic               csr_select,
  output logic [15:0]        bus_data_in
);
  import mbsi_pkg::*;
  int gap = 0;                                             // Extra cycles, slow host
  // Idle bus: all strobes negated
  initial begin
    bus_in = 6'h3F;
    address_hit = 1'b0;
    addr_bit0 = 1'b0;
    csr_select = 1'b0;
    bus_data_in = DATA_ZERO;
  end
  // Hold the current step for gap cycles
  task automatic stall;
    repeat (gap) @(posedge clk);
  endtask : stall
  // Wait up to 20 edges for reply to reach level v
  task automatic wrep(input logic v);
    int n;
    n = 0;
    while (reply_oe_r !== v && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask : wrep
  // Write cycle; lanes taken at the reply edge, ok if replied
  task automatic wr(input logic h, c, wb, a, input logic [15:0] d,
                    output logic [1:0] ln, output logic ok);
    address_hit <= h;
    csr_select <= c;
    addr_bit0 <= a;
    bus_data_in <= d;
    bus_in.wtbt_n <= 1'b0;
    bus_in.sync_n <= 1'b0;
    @(posedge clk);
    bus_in.wtbt_n <= wb;
    bus_in.dout_n <= 1'b0;
    @(posedge clk);
    wrep(1'b1);
    ln = lanes;
    ok = reply_oe_r;
    stall();
    bus_data_in <= ~d;
    bus_in.dout_n <= 1'b1;
    wrep(1'b0);
    stall();
    bus_in.sync_n <= 1'b1;
    bus_in.wtbt_n <= 1'b1;
    address_hit <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : wr
  // Answer a request with read strobe then acknowledge; v is the vector
  task automatic ack(output logic [15:0] v, output logic ok);
    int n;
    n = 0;
    v = DATA_ZERO;
    while (irq_oe_r !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    ok = irq_oe_r;
    if (ok) begin
      bus_in.din_n <= 1'b0;
      @(posedge clk);
      bus_in.iaki_n <= 1'b0;
      wrep(1'b1);
      v = bus_data_out_r;
      stall();
      bus_in.din_n <= 1'b1;
      @(posedge clk);
      bus_in.iaki_n <= 1'b1;
      wrep(1'b0);
    end
    @(posedge clk);
  endtask : ack
  // Bus initialize held for three cycles
  task automatic init_pulse;
    bus_in.init_n <= 1'b0;
    repeat (3) @(posedge clk);
    bus_in.init_n <= 1'b1;
    @(posedge clk);
  endtask : init_pulse
endmodule : mbsi_host

/* sim/tb_mbsi_top.sv */
/*
  Self-checking bench: write lanes, enables, vectored interrupts, clears.
  Assumes mbsi_top, its checker and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb_mbsi_top;
  import mbsi_pkg::*;
  logic clk, rstn, address_hit, addr_bit0, csr_select, read_drive, dtr_write, ok;
  logic reply_oe_r, irq_oe_r, iako_n_r, bus_data_oe_r, low_byte_write_r, high_byte_write_r;
  logic reg_select_r, master_clear_pulse_r, modem_line_clear_r, vector_drive_r;
  logic vector_bit_two_sel_r, rx_interrupt_enable_r, alarm_interrupt_enable_r;
  logic tx_interrupt_enable_r, clear_readback_r;
  logic [15:0] bus_data_in, read_data, bus_data_out_r, v;
  logic [5:0]  vector_switches;
  logic [3:0]  dtr_data, terminal_ready_bits_r;
  logic [1:0]  ln;
  mbsi_bus_s   bus_in;
  mbsi_core_s  core_in;
  int          num_errors = 0;
  int          checks = 0;
  localparam logic [1:0] LANE [4] = '{2'h3, 2'h1, 2'h2, LANE_NONE};
  mbsi_top mbsi_top_inst (.clk, .rstn, .bus_in, .address_hit, .addr_bit0, .csr_select,
    .bus_data_in, .read_drive, .read_data, .core_in, .vector_switches, .dtr_write,
    .dtr_data, .reply_oe_r, .irq_oe_r, .iako_n_r, .bus_data_out_r, .bus_data_oe_r,
    .low_byte_write_r, .high_byte_write_r, .reg_select_r, .master_clear_pulse_r,
    .modem_line_clear_r, .terminal_ready_bits_r, .vector_drive_r, .vector_bit_two_sel_r,
    .rx_interrupt_enable_r, .alarm_interrupt_enable_r, .tx_interrupt_enable_r,
    .clear_readback_r);
  mbsi_host host_inst (.clk, .reply_oe_r, .irq_oe_r, .bus_data_out_r,
    .lanes({high_byte_write_r, low_byte_write_r}), .bus_in, .address_hit, .addr_bit0,
    .csr_select, .bus_data_in);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Master clear by a control word write, then wait for read-back to end
  task automatic mclr;
    int n;
    n = 0;
    host_inst.wr(1'b1, 1'b1, 1'b1, 1'b0, 16'h0010, ln, ok);
    chk("clear pulse", {master_clear_pulse_r, clear_readback_r}, 2'h3);
    while (clear_readback_r !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("clear done", {irq_oe_r, rx_interrupt_enable_r, tx_interrupt_enable_r, clear_readback_r},
        4'h0);
  endtask : mclr
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    read_drive = 1'b0;
    read_data = DATA_ZERO;
    core_in = 3'h0;
    vector_switches = 6'h2D;
    dtr_write = 1'b0;
    dtr_data = DTR_ZERO;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("reset", {iako_n_r, reply_oe_r, irq_oe_r, vector_drive_r, clear_readback_r}, 5'h10);
    // Word, low byte, high byte, no hit; host slows each time
    for (int i = 0; i < 4; i++) begin
      host_inst.gap = i;
      host_inst.wr(i < 3, 1'b0, i == 0, i == 2, 16'h1234, ln, ok);
      chk("reply", ok, i < 3);
      chk("lanes", ln, LANE[i]);
      chk("select", reg_select_r, 1'b0);
    end
    $display("test lanes done");
    // Alarm enable hides receiver done; alarm gives a receiver vector
    core_in <= 3'b100;
    host_inst.wr(1'b1, 1'b1, 1'b1, 1'b0, 16'h1040, ln, ok);
    chk("enables", {rx_interrupt_enable_r, alarm_interrupt_enable_r, tx_interrupt_enable_r},
        3'b110);
    repeat (5) @(posedge clk);
    chk("done hidden", irq_oe_r, 1'b0);
    core_in <= 3'b110;
    host_inst.ack(v, ok);
    chk("alarm vector", v, {7'h00, vector_switches, 3'h0});
    chk("alarm on entry", alarm_interrupt_enable_r, 1'b1);
    core_in <= 3'h0;
    mclr();
    $display("test alarm done");
    // Receiver wins the chain; disabling it withdraws its request
    core_in <= 3'b101;
    host_inst.wr(1'b1, 1'b1, 1'b1, 1'b0, 16'h4040, ln, ok);
    host_inst.ack(v, ok);
    chk("first vector", v, {7'h00, vector_switches, 3'h0});
    core_in <= 3'b001;
    host_inst.wr(1'b1, 1'b1, 1'b1, 1'b0, 16'h4000, ln, ok);
    host_inst.ack(v, ok);
    chk("tx vector", v, {7'h00, vector_switches, 3'h4});
    chk("chain out", {iako_n_r, vector_drive_r}, 2'h2);
    core_in <= 3'h0;
    $display("test priority done");
    // Master clear keeps ready bits; initialize clears them and channels
    dtr_data <= 4'hA;
    dtr_write <= 1'b1;
    @(posedge clk);
    dtr_write <= 1'b0;
    mclr();
    chk("ready bits kept", terminal_ready_bits_r, 4'hA);
    core_in <= 3'b001;
    host_inst.wr(1'b1, 1'b1, 1'b1, 1'b0, 16'h4000, ln, ok);
    host_inst.init_pulse();
    chk("init", {irq_oe_r, tx_interrupt_enable_r, terminal_ready_bits_r}, 6'h00);
    $display("test clears done");
    results();
  end
endmodule : tb_mbsi_top
